// *** src/zone_map_cfg.svh ***
// zone boundaries, fill bytes and timing constants of the sector mapper
// Behaviour
// RL1: each sector maps to exactly one region
// RL2: data region starts at 030000 hex
// RL3: sector numbers rise by one, no gaps
// RL4: lead-in starts 022FA0, seven ordered sub-zones
// RL5: initial sub-zone main data all zero
// RL6: buffer 0: 512 sectors from 02E200, zero
// RL7: format information: 3072 sectors from 02E400
// RL8: format block repeats; offset modulo 16
// RL9: buffer 1, control, extra border starts decoded
// RL10: reference 32, buffer1 480, control 3072, border 512
// RL11: buffer 1 zero; last block is guard
// RL12: reference code byte AC, mostly unscrambled
// RL13: control block: format then manufacturing sector
// RL14: data end is input; beyond is lead-out
// RL15: outputs registered one clock, held until next
`ifndef ZONE_MAP_CFG_SVH
`define ZONE_MAP_CFG_SVH
`define SECTOR_W            24
`define LEAD_IN_START       24'h022FA0
`define BUFFER0_START       24'h02E200
`define FORMAT_INFO_START   24'h02E400
`define REF_CODE_START      24'h02F000
`define BUFFER1_START       24'h02F020
`define CONTROL_START       24'h02F200
`define EXTRA_BORDER_START  24'h02FE00
`define DATA_START          24'h030000
`define BLOCK_SECTORS       16
`define GUARD_START         24'h02F1F0
`define FILL_ZERO           8'h00
`define FILL_REF_CODE       8'hAC
`define REF_SCRAMBLE_BYTES  12'h0A0
`define LATENCY_CYCLES      1
`endif

// *** src/zone_map_pkg.sv ***
// types shared by the sector mapper
package zone_map_pkg;
  // coarse region of a sector
  typedef enum logic [1:0] {
    REGION_NONE,
    REGION_LEAD_IN,
    REGION_DATA,
    REGION_LEAD_OUT
  } region_e;
  // lead-in sub-zone
  typedef enum logic [2:0] {
    SUB_NONE,
    SUB_INITIAL,
    SUB_BUFFER0,
    SUB_FORMAT_INFO,
    SUB_REF_CODE,
    SUB_BUFFER1,
    SUB_CONTROL,
    SUB_EXTRA_BORDER
  } sub_zone_e;
  // role of a sector inside a repeated block
  typedef enum logic [1:0] {
    ROLE_NONE,
    ROLE_FORMAT,
    ROLE_MANUFACTURING,
    ROLE_OTHER
  } block_role_e;
endpackage : zone_map_pkg

// *** src/zone_decode.sv ***
// combinational decode of one sector number into zone codes
`timescale 1ns/1ps
`include "zone_map_cfg.svh"
module zone_decode (
  input  wire logic [23:0]             sector,
  input  wire logic [23:0]             data_end,
  output zone_map_pkg::region_e        region,
  output zone_map_pkg::sub_zone_e      sub_zone,
  output logic                         force_zero,
  output logic                         fill_ref
);
  // start table, walked high to low so later starts win
  always_comb begin
    region     = zone_map_pkg::REGION_NONE;
    sub_zone   = zone_map_pkg::SUB_NONE;
    force_zero = 1'b0;
    fill_ref   = 1'b0;
    if (sector > data_end && sector >= `DATA_START) begin
      region = zone_map_pkg::REGION_LEAD_OUT; // RL14
    end else if (sector >= `DATA_START) begin
      region = zone_map_pkg::REGION_DATA; // RL2
    end else if (sector >= `LEAD_IN_START) begin
      region = zone_map_pkg::REGION_LEAD_IN; // RL1
      if (sector >= `EXTRA_BORDER_START) begin
        sub_zone = zone_map_pkg::SUB_EXTRA_BORDER; // RL9
      end else if (sector >= `CONTROL_START) begin
        sub_zone = zone_map_pkg::SUB_CONTROL; // RL9
      end else if (sector >= `BUFFER1_START) begin
        sub_zone   = zone_map_pkg::SUB_BUFFER1; // RL10
        force_zero = 1'b1; // RL11
      end else if (sector >= `REF_CODE_START) begin
        sub_zone = zone_map_pkg::SUB_REF_CODE; // RL10
        fill_ref = 1'b1; // RL12
      end else if (sector >= `FORMAT_INFO_START) begin
        sub_zone = zone_map_pkg::SUB_FORMAT_INFO; // RL7
      end else if (sector >= `BUFFER0_START) begin
        sub_zone   = zone_map_pkg::SUB_BUFFER0; // RL6
        force_zero = 1'b1; // RL6
      end else begin
        sub_zone   = zone_map_pkg::SUB_INITIAL; // RL4
        force_zero = 1'b1; // RL5
      end
    end
  end
endmodule // zone_decode

// *** src/sector_zone_mapper.sv ***
// sector number to region, sub-zone and fixed-content mapper
`timescale 1ns/1ps
`include "zone_map_cfg.svh"
module sector_zone_mapper (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    sector_valid,
  input  wire logic [23:0]             physical_sector_number,
  input  wire logic [23:0]             data_end_sector,
  output zone_map_pkg::region_e        region_reg,
  output zone_map_pkg::sub_zone_e      sub_zone_reg,
  output zone_map_pkg::block_role_e    block_role_reg,
  output logic [3:0]                   block_offset_reg,
  output logic                         force_zero_reg,
  output logic                         fill_ref_reg,
  output logic [7:0]                   fill_byte_reg,
  output logic [11:0]                  scramble_bytes_reg,
  output logic                         guard_block_reg,
  output logic                         out_valid_reg,
  output logic                         seq_error_reg
);
  // decoded values of the presented sector
  zone_map_pkg::region_e   region_next;
  zone_map_pkg::sub_zone_e sub_zone_next;
  logic                    zero_next;
  logic                    ref_next;
  logic [23:0]             last_sector_reg;  // previous sector seen
  logic                    seen_reg;         // a sector has arrived
  logic [23:0]             expect_sector;    // previous plus one

  // pure decode kept apart so its table reads top to bottom
  zone_decode u_decode (
    .sector     (physical_sector_number),
    .data_end   (data_end_sector),
    .region     (region_next),
    .sub_zone   (sub_zone_next),
    .force_zero (zero_next),
    .fill_ref   (ref_next)
  );

  assign expect_sector = last_sector_reg + 24'h000001;

  // region and sub-zone codes, held between sectors
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      region_reg   <= zone_map_pkg::REGION_NONE;
      sub_zone_reg <= zone_map_pkg::SUB_NONE;
    end else if (sector_valid) begin
      region_reg   <= region_next;   // RL15
      sub_zone_reg <= sub_zone_next; // RL15
    end
  end

  // fill control: zero zones and the reference pattern
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      force_zero_reg     <= 1'b0;
      fill_ref_reg       <= 1'b0;
      fill_byte_reg      <= `FILL_ZERO;
      scramble_bytes_reg <= 12'h000;
    end else if (sector_valid) begin
      force_zero_reg <= zero_next; // RL15
      fill_ref_reg   <= ref_next;
      // reference sectors carry AC; zero elsewhere by default
      fill_byte_reg  <= ref_next ? `FILL_REF_CODE : `FILL_ZERO; // RL12
      // only a block's first sector is partly scrambled
      if (ref_next && physical_sector_number[3:0] == 4'h0) begin
        scramble_bytes_reg <= `REF_SCRAMBLE_BYTES; // RL12
      end else begin
        scramble_bytes_reg <= 12'h000;
      end
    end
  end

  // position in the repeated 16-sector block and its role
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      block_offset_reg <= 4'h0;
      block_role_reg   <= zone_map_pkg::ROLE_NONE;
    end else if (sector_valid) begin
      // zone starts are block aligned, so low bits give modulo 16
      block_offset_reg <= physical_sector_number[3:0]; // RL8
      case (sub_zone_next)
        zone_map_pkg::SUB_FORMAT_INFO: begin
          block_role_reg <= zone_map_pkg::ROLE_OTHER; // RL8
        end
        zone_map_pkg::SUB_CONTROL: begin
          if (physical_sector_number[3:0] == 4'h0) begin
            block_role_reg <= zone_map_pkg::ROLE_FORMAT; // RL13
          end else if (physical_sector_number[3:0] == 4'h1) begin
            block_role_reg <= zone_map_pkg::ROLE_MANUFACTURING; // RL13
          end else begin
            block_role_reg <= zone_map_pkg::ROLE_OTHER;
          end
        end
        default: begin
          block_role_reg <= zone_map_pkg::ROLE_NONE;
        end
      endcase
    end
  end

  // last block of buffer 1 is the block-sync guard area
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      guard_block_reg <= 1'b0;
    end else if (sector_valid) begin
      guard_block_reg <= (sub_zone_next == zone_map_pkg::SUB_BUFFER1) &&
                         (physical_sector_number >= `GUARD_START); // RL11
    end
  end

  // one-cycle marker that fresh codes are on the outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
    end else begin
      out_valid_reg <= sector_valid; // RL15
    end
  end

  // gap watch: the sequencer must step by exactly one
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_sector_reg <= 24'h000000;
      seen_reg        <= 1'b0;
      seq_error_reg   <= 1'b0;
    end else if (sector_valid) begin
      last_sector_reg <= physical_sector_number;
      seen_reg        <= 1'b1;
      // sticky until reset; a restart needs a reset
      if (seen_reg && physical_sector_number != expect_sector) begin
        seq_error_reg <= 1'b1; // RL3
      end
    end
  end

  // checks on the registered outputs
  a_data_region_start: assert property ( // RL2
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number == `DATA_START &&
    data_end_sector >= `DATA_START
    |=> region_reg == zone_map_pkg::REGION_DATA)
    else $error("first data sector not classed as data");

  a_lead_in_start: assert property ( // RL4
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number == `LEAD_IN_START
    |=> sub_zone_reg == zone_map_pkg::SUB_INITIAL && force_zero_reg)
    else $error("lead-in start not initial zero zone");

  a_buffer0_zero: assert property ( // RL6
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number >= `BUFFER0_START &&
    physical_sector_number < `FORMAT_INFO_START
    |=> sub_zone_reg == zone_map_pkg::SUB_BUFFER0 && force_zero_reg)
    else $error("buffer 0 sector not zero filled");

  a_format_span: assert property ( // RL7
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number == `REF_CODE_START - 24'h000001
    |=> sub_zone_reg == zone_map_pkg::SUB_FORMAT_INFO && !force_zero_reg)
    else $error("format information span wrong");

  a_block_offset: assert property ( // RL8
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid |=> block_offset_reg == $past(physical_sector_number[3:0]))
    else $error("block offset not sector modulo 16");

  a_ref_code_fill: assert property ( // RL12
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number >= `REF_CODE_START &&
    physical_sector_number < `BUFFER1_START
    |=> fill_byte_reg == `FILL_REF_CODE && fill_ref_reg)
    else $error("reference code byte missing");

  a_buffer1_guard: assert property ( // RL11
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number == `CONTROL_START - 24'h000001
    |=> guard_block_reg && force_zero_reg)
    else $error("guard block not flagged");

  a_control_first: assert property ( // RL13
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number == `CONTROL_START
    |=> block_role_reg == zone_map_pkg::ROLE_FORMAT)
    else $error("control block first sector not format");

  a_lead_out_past: assert property ( // RL14
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number > data_end_sector &&
    physical_sector_number >= `DATA_START
    |=> region_reg == zone_map_pkg::REGION_LEAD_OUT)
    else $error("sector past data end not lead-out");

  a_outputs_hold: assert property ( // RL15
    @(posedge ref_clk) disable iff (!rst_n)
    !sector_valid |=> $stable(region_reg) && $stable(sub_zone_reg) &&
    $stable(force_zero_reg))
    else $error("outputs changed without a new sector");

  a_gap_flagged: assert property ( // RL3
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && seen_reg && physical_sector_number != expect_sector
    |=> seq_error_reg)
    else $error("sector gap not flagged");

  // whole initial zone, not just its first sector, must be zero filled
  a_initial_zero: assert property ( // RL5
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number >= `LEAD_IN_START &&
    physical_sector_number < `BUFFER0_START
    |=> sub_zone_reg == zone_map_pkg::SUB_INITIAL && force_zero_reg &&
    fill_byte_reg == `FILL_ZERO)
    else $error("initial sector not zero filled");

  // a sub-zone code outside the lead-in would mean two regions at once
  a_one_region: assert property ( // RL1
    @(posedge ref_clk) disable iff (!rst_n)
    sub_zone_reg != zone_map_pkg::SUB_NONE
    |-> region_reg == zone_map_pkg::REGION_LEAD_IN)
    else $error("sub-zone set outside the lead-in");

  a_control_second: assert property ( // RL13
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number == `CONTROL_START + 24'h000001
    |=> block_role_reg == zone_map_pkg::ROLE_MANUFACTURING)
    else $error("control block second sector not manufacturing");

  // border zone carries no fill and no block role
  a_extra_border_start: assert property ( // RL9
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number == `EXTRA_BORDER_START
    |=> sub_zone_reg == zone_map_pkg::SUB_EXTRA_BORDER && !force_zero_reg &&
    block_role_reg == zone_map_pkg::ROLE_NONE)
    else $error("extra border start decoded wrongly");

  // first buffer 1 sector is zero but still well before the guard block
  a_buffer1_start: assert property ( // RL10
    @(posedge ref_clk) disable iff (!rst_n)
    sector_valid && physical_sector_number == `BUFFER1_START
    |=> sub_zone_reg == zone_map_pkg::SUB_BUFFER1 && force_zero_reg &&
    !guard_block_reg)
    else $error("buffer 1 start decoded wrongly");
endmodule // sector_zone_mapper

// *** dv/sector_seq_model.sv ***
// sector sequencer model that feeds sector numbers to the mapper
`timescale 1ns/1ps
module sector_seq_model (
  input  wire logic        ref_clk,
  output logic             sector_valid,
  output logic [23:0]      physical_sector_number
);
  // idle at time zero, nothing presented
  initial begin
    sector_valid           = 1'b0;
    physical_sector_number = 24'h000000;
  end
  // present one sector just after an edge; gap 0 keeps valid up so the
  // next call follows back to back without a second assignment per step
  task automatic send(input logic [23:0] s, input int gap);
    sector_valid           = 1'b1;
    physical_sector_number = s;
    @(posedge ref_clk);
    #1;
    if (gap > 0) begin
      // idle number is the inverse, so a stale value never looks valid
      sector_valid           = 1'b0;
      physical_sector_number = ~s;
      repeat (gap) begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask
endmodule // sector_seq_model

// *** dv/lead_in_zone_sector_mapper_test.sv ***
// self-checking bench for the sector zone mapper
`timescale 1ns/1ps
module lead_in_zone_sector_mapper_test;
  logic                       ref_clk;          // 200 MHz clock
  logic                       rst_n;            // sync reset, active low
  logic                       sector_valid;     // from sequencer model
  logic [23:0]                physical_sector_number;
  logic [23:0]                data_end_sector;  // last data sector
  zone_map_pkg::region_e      region_reg;
  zone_map_pkg::sub_zone_e    sub_zone_reg;
  zone_map_pkg::block_role_e  block_role_reg;
  logic [3:0]                 block_offset_reg;
  logic                       force_zero_reg;
  logic                       fill_ref_reg;
  logic [7:0]                 fill_byte_reg;
  logic [11:0]                scramble_bytes_reg;
  logic                       guard_block_reg;
  logic                       out_valid_reg;
  logic                       seq_error_reg;
  logic [34:0]                seen;             // all codes in one vector
  logic [34:0]                held;             // last reported codes
  logic [34:0]                exp_q[$];         // expected, oldest first
  logic [23:0]                last;             // previous sector sent
  logic                       have_last;        // no jump check on first
  logic                       err_exp;          // sticky jump expectation
  logic                       took;             // sector taken last edge
  logic                       rsd;              // reset seen last edge
  int                         mismatches;
  int                         checks_done;

  assign seen = {region_reg, sub_zone_reg, block_role_reg, block_offset_reg,
                 force_zero_reg, fill_ref_reg, fill_byte_reg,
                 scramble_bytes_reg, guard_block_reg, seq_error_reg};

  // clock: invert every half period
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  sector_seq_model u_sector_seq_model (
    .ref_clk                (ref_clk),
    .sector_valid           (sector_valid),
    .physical_sector_number (physical_sector_number)
  );

  sector_zone_mapper u_sector_zone_mapper (
    .ref_clk                (ref_clk),
    .rst_n                  (rst_n),
    .sector_valid           (sector_valid),
    .physical_sector_number (physical_sector_number),
    .data_end_sector        (data_end_sector),
    .region_reg             (region_reg),
    .sub_zone_reg           (sub_zone_reg),
    .block_role_reg         (block_role_reg),
    .block_offset_reg       (block_offset_reg),
    .force_zero_reg         (force_zero_reg),
    .fill_ref_reg           (fill_ref_reg),
    .fill_byte_reg          (fill_byte_reg),
    .scramble_bytes_reg     (scramble_bytes_reg),
    .guard_block_reg        (guard_block_reg),
    .out_valid_reg          (out_valid_reg),
    .seq_error_reg          (seq_error_reg)
  );

  // expected codes of one sector, worked out from the zone map
  function automatic logic [34:0] expect_of(input logic [23:0] s,
                                            input logic [23:0] e,
                                            input logic err);
    zone_map_pkg::region_e     r;
    zone_map_pkg::sub_zone_e   z;
    zone_map_pkg::block_role_e b;
    r = zone_map_pkg::REGION_NONE;
    z = zone_map_pkg::SUB_NONE;
    b = zone_map_pkg::ROLE_NONE;
    if (s >= 24'h030000) begin
      r = (s > e) ? zone_map_pkg::REGION_LEAD_OUT : zone_map_pkg::REGION_DATA;
    end else if (s >= 24'h022FA0) begin
      r = zone_map_pkg::REGION_LEAD_IN;
      if (s < 24'h02E200) z = zone_map_pkg::SUB_INITIAL;
      else if (s < 24'h02E400) z = zone_map_pkg::SUB_BUFFER0;
      else if (s < 24'h02F000) z = zone_map_pkg::SUB_FORMAT_INFO;
      else if (s < 24'h02F020) z = zone_map_pkg::SUB_REF_CODE;
      else if (s < 24'h02F200) z = zone_map_pkg::SUB_BUFFER1;
      else if (s < 24'h02FE00) z = zone_map_pkg::SUB_CONTROL;
      else z = zone_map_pkg::SUB_EXTRA_BORDER;
    end
    if (z == zone_map_pkg::SUB_CONTROL && s[3:0] == 4'h0)
      b = zone_map_pkg::ROLE_FORMAT;
    else if (z == zone_map_pkg::SUB_CONTROL && s[3:0] == 4'h1)
      b = zone_map_pkg::ROLE_MANUFACTURING;
    else if (z == zone_map_pkg::SUB_CONTROL ||
             z == zone_map_pkg::SUB_FORMAT_INFO)
      b = zone_map_pkg::ROLE_OTHER;
    return {r, z, b, s[3:0],
            z == zone_map_pkg::SUB_INITIAL || z == zone_map_pkg::SUB_BUFFER0
              || z == zone_map_pkg::SUB_BUFFER1,
            z == zone_map_pkg::SUB_REF_CODE,
            (z == zone_map_pkg::SUB_REF_CODE) ? 8'hAC : 8'h00,
            (z == zone_map_pkg::SUB_REF_CODE && s[3:0] == 4'h0) ?
              12'h0A0 : 12'h000,
            s >= 24'h02F1F0 && s <= 24'h02F1FF, err};
  endfunction

  // one comparison, reported at once on a mismatch
  task automatic check(input logic [34:0] got, input logic [34:0] want);
    checks_done++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  // note the expectation, then hand the sector to the sequencer model
  task automatic put(input logic [23:0] s, input int gap);
    err_exp = err_exp | (have_last && s != last + 24'h000001);
    exp_q.push_back(expect_of(s, data_end_sector, err_exp));
    last      = s;
    have_last = 1'b1;
    u_sector_seq_model.send(s, gap);
  endtask

  // bounded wait for all expectations to be met
  task automatic drain;
    repeat (10) if (exp_q.size() != 0) @(posedge ref_clk);
    if (exp_q.size() != 0) begin
      mismatches++;
      report_and_stop;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // what the mapper saw at each rising edge
  initial begin
    took = 1'b0;
    rsd  = 1'b0;
    held = '0;
  end
  always @(posedge ref_clk) begin
    took <= (sector_valid === 1'b1) && (rst_n === 1'b1);
    rsd  <= (rst_n !== 1'b1);
  end

  // watcher: settled outputs compared at the falling edge
  always @(negedge ref_clk) begin
    check({34'h0, out_valid_reg}, {34'h0, took});
    if (rsd) begin
      check(seen, 35'h0);
      held = '0;
    end else if (out_valid_reg === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("unexpected at %0t: got %h want none", $time, seen);
      end else begin
        check(seen, exp_q.pop_front());
      end
      held = seen;
    end else begin
      check(seen, held);
    end
  end

  // main sequence
  initial begin
    rst_n           = 1'b0;
    data_end_sector = 24'h030010;
    mismatches      = 0;
    checks_done     = 0;
    have_last       = 1'b0;
    err_exp         = 1'b0;
    last            = 24'h000000;
    void'($urandom(85990));
    repeat (20) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    // gapless walk through every boundary, mostly back to back
    for (int s = 'h022F90; s < 'h030030; s++)
      put(s[23:0], ($urandom % 16 == 0) ? 1 : 0);
    put(24'h030030, 2);
    drain;
    // random jumps with a moving data end; flags the sequence error
    repeat (300) begin
      data_end_sector = 24'h030000 + 24'($urandom % 256);
      put(24'h022F00 + 24'($urandom % 'hD200), 1 + $urandom % 2);
    end
    drain;
    // second reset in mid-run clears the sticky error
    rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n     = 1'b1;
    have_last = 1'b0;
    err_exp   = 1'b0;
    put(24'h02F000, 0);
    put(24'h02F001, 0);
    put(24'h02F000, 2);
    drain;
    report_and_stop;
  end
endmodule // lead_in_zone_sector_mapper_test
